// file: timebase_osc.sv
// Package of shared constants and the internal timebase oscillator.
// Assumes one clock domain; all inputs except the async active-low rst_n are synchronous to clk.
package timebase_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned OSC_HALF_PERIOD_NS = 2500;
  localparam int unsigned OSC_HALF_CYCLES    =
    (OSC_HALF_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 : (OSC_HALF_PERIOD_NS / CLK_PERIOD_NS);
  localparam int unsigned STAGES       = 8;
  localparam int unsigned DIV2_BIT     = 0;
  localparam int unsigned DIV256_BIT   = 7;
  localparam logic [7:0]  IDLE_COUNT   = 8'hFF;
  localparam logic [7:0]  START_COUNT  = 8'h00;
  localparam logic [7:0]  COUNT_STEP   = 8'h01;
  localparam logic        OSC_RST_LVL  = 1'b1;

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } tstate_e;
endpackage : timebase_pkg

`timescale 1ns/1ps

module timebase_osc #(
  parameter int unsigned HALF_CYCLES = timebase_pkg::OSC_HALF_CYCLES,
  parameter int unsigned CW          = 24
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic restart,
  output logic      osc_q
);
  import timebase_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
  } osc_s;

  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  osc_s s_q;
  osc_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (!run || restart)
    begin
      // The timing capacitor is discharged: the cycle starts from a fresh phase.
      s_d.cnt = '0;
      s_d.lvl = OSC_RST_LVL;
    end
    else if (s_q.cnt >= LAST)
    begin
      s_d.cnt = '0;
      s_d.lvl = ~s_q.lvl;
    end
    else
    begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.cnt <= '0;
      s_q.lvl <= OSC_RST_LVL;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign osc_q = s_q.lvl;
endmodule : timebase_osc

// file: triggered_timebase_divider.sv
// Triggered fixed timer: timebase feeding an eight stage binary divider.
// Assumes trigger, reset and the timebase pin are synchronous to clk.
`timescale 1ns/1ps

module triggered_timebase_divider #(
  parameter int unsigned OSC_HALF = timebase_pkg::OSC_HALF_CYCLES,
  parameter int unsigned N_STAGES = timebase_pkg::STAGES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic trigger,
  input  wire logic reset_in,
  input  wire logic timing_node,
  input  wire logic timebase_in,
  output logic      timebase_out,
  output logic      timebase_oe,
  output logic      discharge,
  output logic      div2_out,
  output logic      div256_out
);
  import timebase_pkg::*;

  typedef struct packed {
    tstate_e              state;
    logic [N_STAGES-1:0]  count;
    logic                 trig_prev;
    logic                 base_prev;
    logic                 discharge;
    logic                 div2;
    logic                 div256;
    logic                 base_out;
    logic                 base_oe;
  } tim_s;

  tim_s s_q;
  tim_s s_d;

  logic osc_lvl;
  logic ext_mode;
  logic base_lvl;
  logic trig_rise;
  logic base_fall;

  // A grounded timing node stops the oscillator and frees the pin as a clock input.
  assign ext_mode  = ~timing_node;
  assign base_lvl  = ext_mode ? timebase_in : osc_lvl;
  assign trig_rise = trigger & ~s_q.trig_prev;
  assign base_fall = s_q.base_prev & ~base_lvl;

  timebase_osc #(
    .HALF_CYCLES (OSC_HALF)
  ) u_osc (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (timing_node),
    .restart (trig_rise),
    .osc_q   (osc_lvl)
  );

  always_comb
  begin
    s_d           = s_q;
    s_d.trig_prev = trigger;
    s_d.base_prev = base_lvl;
    s_d.discharge = 1'b0;
    case (s_q.state)
      ST_IDLE:
      begin
        s_d.count = IDLE_COUNT[N_STAGES-1:0];
        if (trig_rise)
        begin
          s_d.state     = ST_RUN;
          s_d.count     = START_COUNT[N_STAGES-1:0];
          s_d.discharge = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (trig_rise)
        begin
          s_d.count     = START_COUNT[N_STAGES-1:0];
          s_d.discharge = 1'b1;
        end
        else if (reset_in && !trigger)
        begin
          s_d.state = ST_IDLE;
          s_d.count = IDLE_COUNT[N_STAGES-1:0];
        end
        else if (base_fall)
        begin
          s_d.count = s_q.count + COUNT_STEP[N_STAGES-1:0];
        end
      end
      default:
      begin
        s_d.state = ST_IDLE;
        s_d.count = IDLE_COUNT[N_STAGES-1:0];
      end
    endcase
    // Divider outputs are push-pull, taken straight from the stage flip-flops; the timebase pin drives only while timebase_oe is high.
    s_d.div2   = s_d.count[DIV2_BIT];
    s_d.div256 = s_d.count[N_STAGES-1];
    s_d.base_out = osc_lvl;
    s_d.base_oe  = ~ext_mode;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.state     <= ST_IDLE;
      s_q.count     <= IDLE_COUNT[N_STAGES-1:0];
      s_q.trig_prev <= 1'b1;
      s_q.base_prev <= 1'b0;
      s_q.discharge <= 1'b0;
      s_q.div2      <= 1'b1;
      s_q.div256    <= 1'b1;
      s_q.base_out  <= OSC_RST_LVL;
      s_q.base_oe   <= 1'b0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign timebase_out = s_q.base_out;
  assign timebase_oe  = s_q.base_oe;
  assign discharge    = s_q.discharge;
  assign div2_out     = s_q.div2;
  assign div256_out   = s_q.div256;
endmodule : triggered_timebase_divider

// file: triggered_timebase_divider_properties.sv
// Port checker for the triggered divider.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module triggered_timebase_divider_checker (
  input wire logic clk, rst_n, ce, trigger, reset_in, timing_node, timebase_in,
  input wire logic timebase_oe, discharge, div2_out, div256_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_start_fall: assert property (ce && $rose(trigger)
    |=> discharge && !div2_out && !div256_out) else $error("start");
  chk_disch_pulse: assert property (discharge |=> !discharge) else $error("pulse");
  chk_reset_idle: assert property (ce && reset_in && !trigger
    |=> div2_out && div256_out) else $error("idle");
  chk_trig_wins: assert property (ce && trigger && reset_in && !div256_out
    |=> !div256_out || !div2_out) else $error("prio");
  chk_count_step: assert property (ce && !timing_node && !$past(timing_node)
    && $fell(timebase_in) && !div256_out && !trigger && !reset_in
    |=> div2_out != $past(div2_out)) else $error("step");
  chk_count_hold: assert property (ce && !timing_node && $stable(timing_node)
    && $stable(timebase_in) && !trigger && !reset_in
    |=> $stable({div2_out, div256_out})) else $error("hold");
  chk_msb_rise: assert property ($rose(div256_out)
    |-> !div2_out || $past(reset_in)) else $error("msb");
  chk_oe_mode: assert property ($past(rst_n) && $past(ce)
    |-> timebase_oe == $past(timing_node)) else $error("oe");
  cover property (ce && $rose(trigger));
  cover property ($rose(div256_out));
  cover property (trigger && reset_in);
endmodule : triggered_timebase_divider_checker
bind triggered_timebase_divider triggered_timebase_divider_checker chk (.*);

// file: ext_clock_src.sv
// External clock source for counter-only use.
// Assumes en is driven synchronously to clk.
`timescale 1ns/1ps
module ext_clock_src (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [2:0] half,
  output logic            ext_clk
);
  logic [2:0] cnt_q = 3'h0;
  initial ext_clk = 1'b1;
  // The clock stands high outside a frame so no stray fall is counted.
  always @(posedge clk)
    if (!en) {ext_clk, cnt_q} <= 4'h8;
    else if (cnt_q == half - 3'h1) {ext_clk, cnt_q} <= {~ext_clk, 3'h0};
    else cnt_q <= cnt_q + 3'h1;
endmodule : ext_clock_src

// file: triggered_timebase_divider_test.sv
// Self-checking bench for the triggered divider.
// Assumes the checker file and the clock source model are compiled too.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module triggered_timebase_divider_test;
  logic clk = 0, rst_n = 0, ce = 1, trigger = 0, reset_in = 0, timing_node = 0;
  logic en = 0, mono = 0, ext_clk, disch, d2, d256, oe, tbo;
  logic [2:0] half = 3'h2, v, e, last = 3'h3;
  logic [2:0] q[$];
  int fail_count = 0, samples_checked = 0, i;
  always #2.5 clk = ~clk;
  ext_clock_src src (.clk(clk), .en(en), .half(half), .ext_clk(ext_clk));
  triggered_timebase_divider #(.OSC_HALF(2)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .trigger(trigger), .reset_in(reset_in), .timing_node(timing_node), .timebase_in(ext_clk),
    .timebase_out(tbo), .timebase_oe(oe), .discharge(disch), .div2_out(d2), .div256_out(d256));
  always @(posedge clk) if (mono) reset_in <= d256;
  always @(negedge clk) if (rst_n) begin
    v = {disch, d2, d256};
    if (v !== last) begin
      e = q.size() ? q.pop_front() : 3'h7;
      `CHK(v, e)
      last = v;
    end
  end
  task end_sim;
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task shot(input logic node, input logic hold);
    q.push_back(3'h4);
    q.push_back(3'h0);
    if (!hold) for (i = 1; i <= 128; i++) q.push_back({1'b0, i[0], i[7]});
    q.push_back(3'h3);
    timing_node <= node; reset_in <= hold; mono <= !hold; trigger <= 1'b1;
    half <= 3'($urandom_range(5, 2));
    @(posedge clk) en <= !node && !hold;
    repeat (6) @(posedge clk);
    trigger <= 1'b0;
    for (i = 0; i < 3000 && q.size() > 0; i++) @(posedge clk);
    `CHK(q.size(), 0)
    `CHK(oe, node)
    if (!node) `CHK(tbo, 1'b1)
    en <= 1'b0; mono <= 1'b0; reset_in <= 1'b0;
    @(posedge clk);
  endtask : shot
  initial begin
    void'($urandom(92));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1; reset_in <= 1'b1;
    @(posedge clk) reset_in <= 1'b0;
    @(negedge clk);
    `CHK({d2, d256}, 2'h3)
    @(posedge clk) shot(1'b0, 1'b0);
    shot(1'b1, 1'b0);
    shot(1'b0, 1'b1);
    end_sim;
  end
  initial begin repeat (20000) @(posedge clk); fail_count++; end_sim; end
endmodule : triggered_timebase_divider_test
